// ---- bench/sss_mcu_model.sv ----
// microcontroller that runs only while its supplies are reported good
`timescale 1ns/1ps
module sss_mcu_model (
  input  wire clk_i,
  input  wire rail1_reset_n_i,
  input  wire rail2_reset_n_i,
  input  wire power_good_i,
  output reg  running_o
);
  // leaves reset only when every supply line is released
  always @(posedge clk_i) begin
    running_o <= rail1_reset_n_i & rail2_reset_n_i & power_good_i;
  end
endmodule // sss_mcu_model

// ---- bench/sss_supervisor_assertions.sv ----
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
module sss_checker #(
  parameter WAKE_LOW_CYC = 25000
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire wake_i,
  input wire watchdog_fault_i,
  input wire temp_above_upper_i,
  input wire temp_above_shutdown_i,
  input wire internal_enable_o,
  input wire first_stage_enable_o,
  input wire second_stage_enable_o,
  input wire watchdog_fault_n_o,
  input wire thermal_warning_n_o,
  input wire safe_o
);
  reg        wake_d;
  reg [15:0] held;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // cycles for which wake has kept its level
  always @(posedge clk_i) begin
    wake_d <= wake_i;
    if (rst_i || wake_i != wake_d)
      held <= 16'h0000;
    else if (held != 16'hffff)
      held <= held + 16'h0001;
  end
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  // threshold allows for the input synchroniser
  chk_wake_start: assert property ($rose(internal_enable_o) |-> wake_i && held >= 16'h0ea1)
    else $error("regulators started before wake filter ran out");
  chk_first_after: assert property ($rose(first_stage_enable_o) |-> internal_enable_o)
    else $error("first stage enabled without internal regulators");
  chk_second_after: assert property ($rose(second_stage_enable_o) |-> internal_enable_o)
    else $error("second stage enabled without internal regulators");
  chk_wake_off: assert property (!wake_i && held == WAKE_LOW_CYC + 8 |->
    !internal_enable_o && !first_stage_enable_o && !second_stage_enable_o)
    else $error("outputs still on after wake low filter");
  chk_wdg_out: assert property ($rose(watchdog_fault_i) |-> ##[1:12] !watchdog_fault_n_o)
    else $error("watchdog fault output not driven low");
  chk_warn_out: assert property ($rose(temp_above_upper_i) |-> ##[1:12] !thermal_warning_n_o)
    else $error("thermal warning output not driven low");
  chk_safe_entry: assert property ($rose(temp_above_shutdown_i) |-> ##[1:12] safe_o)
    else $error("safe state not entered on shutdown temperature");
  cov_power_up: cover property ($rose(second_stage_enable_o));
  cov_safe_exit: cover property ($fell(safe_o));
  cov_wdg_fault: cover property ($fell(watchdog_fault_n_o));
endmodule // sss_checker
bind sss_supervisor sss_checker #(.WAKE_LOW_CYC(WAKE_LOW_CYC)) sss_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .wake_i(wake_i),
  .watchdog_fault_i(watchdog_fault_i), .temp_above_upper_i(temp_above_upper_i),
  .temp_above_shutdown_i(temp_above_shutdown_i), .internal_enable_o(internal_enable_o),
  .first_stage_enable_o(first_stage_enable_o), .second_stage_enable_o(second_stage_enable_o),
  .watchdog_fault_n_o(watchdog_fault_n_o), .thermal_warning_n_o(thermal_warning_n_o),
  .safe_o(safe_o));

// ---- bench/tb_top.sv ----
// self-checking bench of the supply sequencer supervisor
`timescale 1ns/1ps
`include "sss_defines.vh"
module tb_top;
  localparam FILT = 4;
  localparam REL  = 8;
  localparam WLOW = 50;
  localparam WHI  = `SSS_WAKE_HIGH_CYC;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, wake, bat, rdy, r1_ov, ov2, wdg, t_up, t_lo;
  reg         t_sd, r2_uv, cv_uv, bov_h, bov_l, pump_low;
  reg  [1:0]  r1_sel;
  reg  [2:0]  r1_uv;
  reg  [3:0]  adr_i;
  reg  [31:0] dat_i, q;
  wire [31:0] dat_o;
  wire        ack_o, irq, ie, f1, f2, cv, r1n, r2n, pg, wdn, warn_n, safe, latch, run;
  integer     fail_count, tests_run, i;
  sss_supervisor #(.WAKE_LOW_CYC(WLOW), .FILT_CYC(FILT), .REL_CYC(REL)) sss_supervisor_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq), .wake_i(wake),
    .battery_above_start_i(bat), .battery_ov_high_i(bov_h), .battery_ov_low_i(bov_l),
    .battery_uv_low_i(1'b0), .battery_uv_high_i(bat), .charge_pump_uv_i(pump_low),
    .internal_ready_i(rdy), .rail1_sense_uv_i(r1_uv), .rail1_sense_ov_i(r1_ov),
    .rail1_voltage_select_i(r1_sel), .rail2_feedback_uv_i(r2_uv), .rail2_feedback_ov_i(ov2),
    .converter_supply_uv_i(cv_uv), .converter_supply_ov_i(ov2), .watchdog_fault_i(wdg),
    .temp_above_upper_i(t_up), .temp_below_lower_i(t_lo), .temp_above_shutdown_i(t_sd),
    .internal_enable_o(ie), .first_stage_enable_o(f1), .second_stage_enable_o(f2),
    .converter_enable_o(cv), .rail1_reset_n_o(r1n), .rail2_reset_n_o(r2n),
    .converter_power_good_o(pg), .watchdog_fault_n_o(wdn), .thermal_warning_n_o(warn_n),
    .safe_o(safe), .latch_o(latch));
  sss_mcu_model sss_mcu_model_i (.clk_i(clk_i), .rail1_reset_n_i(r1n), .rail2_reset_n_i(r2n),
    .power_good_i(pg), .running_o(run));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task check(input string what, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic bus cycle, held until ack is sampled
  task wb(input w, input [3:0] a, input [31:0] d);
    integer n;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n = n + 1;
    end
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    check("bus ack", ack_o, 1);
    @(posedge clk_i);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    wb(0, `SSS_ADR_STATUS, 0);
    check("status reset", q, 32'h000000c0);
    wb(1, 4'h2, 32'hffffffff);
    wb(0, 4'h2, 0);
    check("unmapped", q, 0);
  endtask
  task t_power;
    wake <= 1'b1;
    wait_cyc(WHI + 40);
    check("battery low", ie, 0);
    wake <= 1'b0;
    wait_cyc(WLOW + 12);
    {bat, wake} <= 2'h3;
    wait_cyc(WHI - 20);
    check("wake early", ie, 0);
    wait_cyc(40);
    check("wake done", ie, 1);
    check("rails held", {f1, r1n, r2n, pg}, 0);
    rdy <= 1'b1;
    wait_cyc(10);
    check("first stage", {f1, f2, cv}, 3'h4);
    r1_uv <= 3'h0;
    wait_cyc(REL + 12);
    check("second stage", {f1, f2, cv}, 3'h7);
    check("rail1 only", {r1n, r2n, pg}, 3'h4);
    {r2_uv, cv_uv} <= 2'h0;
    wait_cyc(REL + 12);
    check("all good", {r2n, pg, run}, 3'h7);
  endtask
  task t_faults;
    wb(1, `SSS_ADR_IRQ_MASK, 32'h00000001);
    r1_ov <= 1'b1;
    wait_cyc(FILT - 1);
    r1_ov <= 1'b0;
    wait_cyc(8);
    check("short fault", {r1n, irq}, 2'h2);
    r1_ov <= 1'b1;
    wait_cyc(FILT + 8);
    check("rail1 fault", {r1n, run, irq}, 3'h1);
    r1_ov <= 1'b0;
    wait_cyc(REL - 3);
    check("release wait", r1n, 0);
    wb(1, `SSS_ADR_IRQ_MASK, 0);
    check("irq masked", irq, 0);
    wait_cyc(REL + 6);
    check("rail1 back", r1n, 1);
    wb(1, `SSS_ADR_IRQ_STAT, 32'h00000001);
    wb(0, `SSS_ADR_IRQ_STAT, 0);
    check("irq clear", q[`SSS_IRQ_R1], 0);
    ov2 <= 1'b1;
    wait_cyc(FILT + 8);
    check("rail2 fault", {r2n, pg}, 0);
    ov2 <= 1'b0;
    wait_cyc(REL + FILT + 12);
    check("rail2 back", {r2n, pg}, 2'h3);
    for (i = 0; i < 3; i = i + 1) begin
      {r1_sel, r1_uv} <= {i[1:0], 3'h7 ^ (3'h1 << i)};
      wait_cyc(FILT + REL + 12);
      check("uv other", r1n, 1);
      r1_uv <= 3'h1 << i;
      wait_cyc(FILT + 8);
      check("uv chosen", r1n, 0);
    end
    {r1_sel, r1_uv} <= 5'h00;
  endtask
  task t_thermal;
    {t_up, t_lo} <= 2'h2;
    wait_cyc(12);
    check("warn on", warn_n, 0);
    t_up <= 1'b0;
    wait_cyc(12);
    check("warn held", warn_n, 0);
    t_lo <= 1'b1;
    wait_cyc(12);
    check("warn off", warn_n, 1);
    {t_sd, t_lo} <= 2'h2;
    wait_cyc(12);
    check("safe entry", {safe, f1, f2, cv}, 4'h8);
    t_sd <= 1'b0;
    wait_cyc(12);
    check("safe held", safe, 1);
    t_lo <= 1'b1;
    wait_cyc(12);
    check("safe exit", safe, 0);
  endtask
  task t_off_unused;
    wake <= 1'b0;
    wait_cyc(WLOW - 10);
    check("still on", ie, 1);
    wait_cyc(22);
    check("all off", {ie, f1, f2, cv, r1n, r2n, pg}, 0);
    wb(1, `SSS_ADR_CTRL, 32'h00000001);
    {r1_uv, wake} <= 4'hf;
    wait_cyc(WHI + 40);
    check("unused start", {f1, f2, cv}, 3'h3);
  endtask
  task t_watchdog;
    for (i = 0; i < 2; i = i + 1) begin
      check("no latch", latch, 0);
      wdg <= 1'b1;
      wait_cyc(12);
      check("wdg out", wdn, 0);
      wdg <= 1'b0;
      wait_cyc(12);
    end
    check("latched", latch, 1);
    wb(1, `SSS_ADR_CTRL, 32'h00000002);
    wait_cyc(2);
    check("latch clear", latch, 0);
  endtask
  // battery over-voltage window and charge-pump under-voltage
  task t_protect;
    {bov_h, bov_l} <= 2'h3;
    wait_cyc(FILT + 8);
    check("battery ov", {safe, ie}, 2'h2);
    bov_h <= 1'b0;
    wait_cyc(FILT + 8);
    check("ov hysteresis", safe, 1);
    bov_l <= 1'b0;
    wait_cyc(FILT + 8);
    check("ov leave", {safe, ie}, 2'h1);
    pump_low <= 1'b1;
    wait_cyc(FILT - 1);
    pump_low <= 1'b0;
    wait_cyc(8);
    check("pump short", safe, 0);
    pump_low <= 1'b1;
    wait_cyc(FILT + 8);
    check("pump low", {safe, ie}, 2'h2);
    pump_low <= 1'b0;
    wait_cyc(FILT + 8);
    check("pump back", {safe, ie}, 2'h1);
  endtask
  // free-running bench clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // cuts a hang short well after the expected run length
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    wrap_up;
  end
  // reset, then the scenarios in turn
  initial begin
    fail_count = 0;
    tests_run = 0;
    {cyc_i, stb_i, we_i, wake, bat, rdy, r1_ov, ov2, wdg, t_up, t_sd} = 11'h000;
    {r2_uv, cv_uv, t_lo, r1_uv, r1_sel, adr_i, dat_i} = {6'h3f, 2'h0, 4'h0, 32'h0};
    {bov_h, bov_l, pump_low} = 3'h0;
    rst_i = 1'b1;
    wait_cyc(4);
    rst_i <= 1'b0;
    t_regs;
    t_power;
    t_faults;
    t_thermal;
    t_off_unused;
    t_watchdog;
    t_protect;
    wrap_up;
  end
endmodule // tb_top

// ---- rtl/sss_defines.vh ----
// timing constants and register map of the supply sequencer supervisor
`ifndef SSS_DEFINES_VH
`define SSS_DEFINES_VH
// clock rate in kHz
`define SSS_CLK_KHZ          25000
// wake filter times as printed
`define SSS_WAKE_HIGH_US     150
`define SSS_WAKE_LOW_MS      1
`define SSS_WAKE_HIGH_CYC    ((`SSS_WAKE_HIGH_US * `SSS_CLK_KHZ) / 1000)
`define SSS_WAKE_LOW_CYC     (`SSS_WAKE_LOW_MS * `SSS_CLK_KHZ)
// filter and release defaults in cycles (no figure given)
`define SSS_FILT_CYC         64
`define SSS_REL_CYC          256
`define SSS_LATCH_CNT        3
// register byte addresses
`define SSS_ADR_STATUS       4'h0
`define SSS_ADR_IRQ_STAT     4'h4
`define SSS_ADR_IRQ_MASK     4'h8
`define SSS_ADR_CTRL         4'hc
// control register fields
`define SSS_CTRL_RAIL1_UNUSED 0
`define SSS_CTRL_LATCH_CLR    1
`define SSS_CTRL_RESET        8'h00
// interrupt bit positions
`define SSS_IRQ_R1            0
`define SSS_IRQ_R2            1
`define SSS_IRQ_CNV           2
`define SSS_IRQ_WDG           3
`define SSS_IRQ_TW            4
`define SSS_IRQ_SAFE          5
`define SSS_IRQ_LATCH         6
`define SSS_IRQ_W             7
`endif

// ---- rtl/sss_supervisor.v ----
// supply sequencer and supervisor with wishbone registers
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "sss_defines.vh"
//
// Notes on behaviour
// - internal regulators start when battery above 5.5 V and wake held high 150 us
// - first-stage regulator is enabled first after internal regulators ready
// - second-stage and converter regulators enable after rail1 passes under-voltage level
// - with first stage unused, second and converter start right after internal ready
// - wake low for 1 ms turns off internal regulators and all regulator enables, and drives resets and power good low
// - filtered rail1 fault drives rail1 reset low, released after fixed delay
// - filtered rail2 fault holds rail2 reset low, released after delay
// - filtered converter fault drives power good low, released after delay
// - watchdog fault drives watchdog fault output low while on
// - thermal warning low above upper, released below lower threshold
// - shutdown temperature enters SAFE, returns below lower warning temperature
// - at power-up resets and power good stay low until own rail is good
// - battery over or under voltage filtered enters SAFE, opposite level filtered leaves
// - filtered charge-pump under-voltage enters SAFE, filtered recovery leaves
// - repeated charge-pump, watchdog or thermal shutdown faults enter latch state
// - rail1 under-voltage threshold selected by low, mid or high select level
//
module sss_filter #(
  parameter N = 64
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire cond_i,
  output reg  flag_o
);
  reg [15:0] cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      cnt_reg <= 16'h0000;
      flag_o  <= 1'b0;
    end else if (cnt_reg >= N[15:0] - 16'h0001) begin
      flag_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule // sss_filter

module sss_supervisor #(
  parameter WAKE_LOW_CYC = `SSS_WAKE_LOW_CYC,
  parameter FILT_CYC     = `SSS_FILT_CYC,
  parameter REL_CYC      = `SSS_REL_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output wire        irq_o,
  // comparator and pin inputs, asynchronous
  input  wire        wake_i,
  input  wire        battery_above_start_i,
  input  wire        battery_ov_high_i,
  input  wire        battery_ov_low_i,
  input  wire        battery_uv_low_i,
  input  wire        battery_uv_high_i,
  input  wire        charge_pump_uv_i,
  input  wire        internal_ready_i,
  input  wire [2:0]  rail1_sense_uv_i,
  input  wire        rail1_sense_ov_i,
  input  wire [1:0]  rail1_voltage_select_i,
  input  wire        rail2_feedback_uv_i,
  input  wire        rail2_feedback_ov_i,
  input  wire        converter_supply_uv_i,
  input  wire        converter_supply_ov_i,
  input  wire        watchdog_fault_i,
  input  wire        temp_above_upper_i,
  input  wire        temp_below_lower_i,
  input  wire        temp_above_shutdown_i,
  // regulator enables
  output reg         internal_enable_o,
  output reg         first_stage_enable_o,
  output reg         second_stage_enable_o,
  output reg         converter_enable_o,
  // open-drain style outputs, active-low except power good, then active-high safe and latch flags
  output reg         rail1_reset_n_o,
  output reg         rail2_reset_n_o,
  output reg         converter_power_good_o,
  output reg         watchdog_fault_n_o,
  output reg         thermal_warning_n_o,
  output wire        safe_o,
  output wire        latch_o
);

  // ************************************************
  // input synchronisers
  // ************************************************
  localparam NI = 20;
  wire [NI-1:0] raw_w = {wake_i, battery_above_start_i, battery_ov_high_i, battery_ov_low_i,
                         battery_uv_low_i, battery_uv_high_i, charge_pump_uv_i,
                         internal_ready_i, rail1_sense_ov_i, rail2_feedback_uv_i,
                         rail2_feedback_ov_i, converter_supply_uv_i, converter_supply_ov_i,
                         watchdog_fault_i, temp_above_upper_i, temp_below_lower_i,
                         temp_above_shutdown_i, rail1_voltage_select_i[1:0],
                         1'b0};
  reg  [NI-1:0] s1_reg;
  reg  [NI-1:0] s2_reg;
  reg  [2:0]    uv1_s1_reg;
  reg  [2:0]    uv1_s2_reg;
  // two flops per asynchronous input
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg     <= {NI{1'b0}};
      s2_reg     <= {NI{1'b0}};
      uv1_s1_reg <= 3'h0;
      uv1_s2_reg <= 3'h0;
    end else begin
      s1_reg     <= raw_w;
      s2_reg     <= s1_reg;
      uv1_s1_reg <= rail1_sense_uv_i;
      uv1_s2_reg <= uv1_s1_reg;
    end
  end
  wire       wake_w, bstart, bovh, bovl, buvl, buvh, cpuv, iready, r1ov;
  wire       r2uv, r2ov, cnuv, cnov, wdf, tup, tlow, tshut;
  wire [1:0] vsel;
  // synchronised levels by name, bit 0 is spare
  assign {wake_w, bstart, bovh, bovl, buvl, buvh, cpuv, iready, r1ov, r2uv, r2ov, cnuv, cnov,
          wdf, tup, tlow, tshut, vsel} = s2_reg[NI-1:1];

  wire r1uv = (vsel == 2'h0) ? uv1_s2_reg[0] :
              (vsel == 2'h1) ? uv1_s2_reg[1] : uv1_s2_reg[2];

  // ************************************************
  // filters
  // ************************************************
  wire wake_hi_f, wake_lo_f, r1_f, r2_f, cn_f, bov_f, bovr_f;
  wire buv_f, buvr_f, cp_f, cpr_f;
  wire [10:0] cond_w = {wake_w, !wake_w, r1uv | r1ov, r2uv | r2ov, cnuv | cnov, bovh, !bovl,
                        buvl, buvh, cpuv, !cpuv};
  wire [10:0] flag_w;
  assign {wake_hi_f, wake_lo_f, r1_f, r2_f, cn_f, bov_f, bovr_f, buv_f, buvr_f, cp_f, cpr_f}
    = flag_w;
  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1) begin : g_filt
      sss_filter #(
        .N (g == 10 ? `SSS_WAKE_HIGH_CYC : (g == 9 ? WAKE_LOW_CYC : FILT_CYC))
      ) u_filt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cond_i (cond_w[g]),
        .flag_o (flag_w[g])
      );
    end
  endgenerate

  // ************************************************
  // registers and control state
  // ************************************************
  reg [7:0]  ctrl_reg;
  reg [7:0]  ists_reg;
  reg [7:0]  imask_reg;
  reg        on_reg;
  reg        safe_bov_reg, safe_buv_reg, safe_cp_reg, safe_hot_reg;
  reg        latch_reg;
  reg [3:0]  fault_cnt_reg;
  reg        hot_d_reg, cp_d_reg, wdf_d_reg, warn_n_d_reg, safe_d_reg;
  reg        r1_ok_reg, r2_ok_reg, cn_ok_reg;
  wire       safe_w = safe_bov_reg | safe_buv_reg | safe_cp_reg | safe_hot_reg;
  wire       run_w  = on_reg & !safe_w & !latch_reg;
  assign safe_o  = safe_w;
  assign latch_o = latch_reg;
  assign irq_o   = |(ists_reg & imask_reg);

  // power state and protection modes
  always @(posedge clk_i) begin
    if (rst_i) begin
      on_reg        <= 1'b0;
      safe_bov_reg  <= 1'b0;
      safe_buv_reg  <= 1'b0;
      safe_cp_reg   <= 1'b0;
      safe_hot_reg  <= 1'b0;
      latch_reg     <= 1'b0;
      fault_cnt_reg <= 4'h0;
      hot_d_reg     <= 1'b0;
      cp_d_reg      <= 1'b0;
      wdf_d_reg     <= 1'b0;
    end else begin
      hot_d_reg <= tshut;
      cp_d_reg  <= cp_f;
      wdf_d_reg <= wdf;
      if (!on_reg && wake_hi_f && bstart)
        on_reg <= 1'b1;
      else if (wake_lo_f)
        on_reg <= 1'b0;
      if (bov_f)
        safe_bov_reg <= 1'b1;
      else if (bovr_f)
        safe_bov_reg <= 1'b0;
      if (buv_f)
        safe_buv_reg <= 1'b1;
      else if (buvr_f)
        safe_buv_reg <= 1'b0;
      if (cp_f)
        safe_cp_reg <= 1'b1;
      else if (cpr_f)
        safe_cp_reg <= 1'b0;
      if (tshut)
        safe_hot_reg <= 1'b1;
      else if (tlow)
        safe_hot_reg <= 1'b0;
      if ((tshut & !hot_d_reg) | (cp_f & !cp_d_reg) | (wdf & !wdf_d_reg)) begin
        if (fault_cnt_reg >= `SSS_LATCH_CNT - 1)
          latch_reg <= 1'b1;
        else
          fault_cnt_reg <= fault_cnt_reg + 4'h1;
      end else if (we_i && cyc_i && stb_i && ack_o && adr_i == `SSS_ADR_CTRL
                   && dat_i[`SSS_CTRL_LATCH_CLR]) begin
        latch_reg     <= 1'b0;
        fault_cnt_reg <= 4'h0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || !run_w) begin
      internal_enable_o     <= 1'b0;
      first_stage_enable_o  <= 1'b0;
      second_stage_enable_o <= 1'b0;
      converter_enable_o    <= 1'b0;
    end else begin
      internal_enable_o    <= 1'b1;
      first_stage_enable_o <= iready & !ctrl_reg[`SSS_CTRL_RAIL1_UNUSED];
      if (iready && (ctrl_reg[`SSS_CTRL_RAIL1_UNUSED] || (first_stage_enable_o && !r1uv))) begin
        second_stage_enable_o <= 1'b1;
        converter_enable_o    <= 1'b1;
      end
    end
  end

  // ************************************************
  // reset and power good outputs
  // ************************************************
  reg [15:0] r1_rel_reg, r2_rel_reg, cn_rel_reg;
  always @(posedge clk_i) begin
    if (rst_i || !run_w) begin
      r1_rel_reg <= 16'h0000;
      r2_rel_reg <= 16'h0000;
      cn_rel_reg <= 16'h0000;
      r1_ok_reg  <= 1'b0;
      r2_ok_reg  <= 1'b0;
      cn_ok_reg  <= 1'b0;
    end else begin
      if (r1_f || r1uv || !first_stage_enable_o) begin
        r1_rel_reg <= 16'h0000;
        r1_ok_reg  <= r1_ok_reg & !r1_f & first_stage_enable_o; // a dip only restarts delay
      end else if (r1_rel_reg >= REL_CYC[15:0] - 16'h0001)
        r1_ok_reg <= 1'b1;
      else
        r1_rel_reg <= r1_rel_reg + 16'h0001;
      if (r2_f || r2uv || !second_stage_enable_o) begin
        r2_rel_reg <= 16'h0000;
        r2_ok_reg  <= r2_ok_reg & !r2_f & second_stage_enable_o;
      end else if (r2_rel_reg >= REL_CYC[15:0] - 16'h0001)
        r2_ok_reg <= 1'b1;
      else
        r2_rel_reg <= r2_rel_reg + 16'h0001;
      if (cn_f || cnuv || !converter_enable_o) begin
        cn_rel_reg <= 16'h0000;
        cn_ok_reg  <= cn_ok_reg & !cn_f & converter_enable_o;
      end else if (cn_rel_reg >= REL_CYC[15:0] - 16'h0001)
        cn_ok_reg <= 1'b1;
      else
        cn_rel_reg <= cn_rel_reg + 16'h0001;
    end
  end

  // drive status outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      rail1_reset_n_o        <= 1'b0;
      rail2_reset_n_o        <= 1'b0;
      converter_power_good_o <= 1'b0;
      watchdog_fault_n_o     <= 1'b1;
      thermal_warning_n_o    <= 1'b1;
    end else begin
      rail1_reset_n_o        <= r1_ok_reg;
      rail2_reset_n_o        <= r2_ok_reg;
      converter_power_good_o <= cn_ok_reg;
      watchdog_fault_n_o     <= !(wdf & on_reg);
      if (tup)
        thermal_warning_n_o <= 1'b0;
      else if (tlow)
        thermal_warning_n_o <= 1'b1;
    end
  end

  // ************************************************
  // wishbone slave and interrupts
  // ************************************************
  wire       wr_w = cyc_i & stb_i & we_i & ack_o; // lands on the edge the master sees ack
  wire [7:0] ev_w;
  assign ev_w[`SSS_IRQ_R1]    = rail1_reset_n_o & !r1_ok_reg;
  assign ev_w[`SSS_IRQ_R2]    = rail2_reset_n_o & !r2_ok_reg;
  assign ev_w[`SSS_IRQ_CNV]   = converter_power_good_o & !cn_ok_reg;
  assign ev_w[`SSS_IRQ_WDG]   = wdf & !wdf_d_reg;
  assign ev_w[`SSS_IRQ_TW]    = warn_n_d_reg & !thermal_warning_n_o;
  assign ev_w[`SSS_IRQ_SAFE]  = safe_w & !safe_d_reg;
  assign ev_w[`SSS_IRQ_LATCH] = 1'b0; // bit kept free
  assign ev_w[`SSS_IRQ_W]     = wake_lo_f & on_reg;

  // one-wait-state slave, write one to clear, set wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h00000000;
      ctrl_reg   <= `SSS_CTRL_RESET;
      ists_reg   <= 8'h00;
      imask_reg  <= 8'h00;
      warn_n_d_reg <= 1'b1;
      safe_d_reg   <= 1'b0;
    end else begin
      warn_n_d_reg <= thermal_warning_n_o;
      safe_d_reg <= safe_w;
      ack_o      <= cyc_i & stb_i & !ack_o;
      ists_reg   <= (ists_reg & ~((wr_w && adr_i == `SSS_ADR_IRQ_STAT && sel_i[0])
                     ? dat_i[7:0] : 8'h00)) | ev_w;
      if (wr_w && sel_i[0] && adr_i == `SSS_ADR_IRQ_MASK)
        imask_reg <= dat_i[7:0];
      if (wr_w && sel_i[0] && adr_i == `SSS_ADR_CTRL)
        ctrl_reg <= {7'h00, dat_i[`SSS_CTRL_RAIL1_UNUSED]};
      case (adr_i)
        `SSS_ADR_STATUS:   dat_o <= {21'h00000, latch_reg, safe_w, on_reg,
                                     thermal_warning_n_o, watchdog_fault_n_o,
                                     converter_power_good_o, rail2_reset_n_o,
                                     rail1_reset_n_o, converter_enable_o,
                                     second_stage_enable_o, first_stage_enable_o};
        `SSS_ADR_IRQ_STAT: dat_o <= {24'h000000, ists_reg};
        `SSS_ADR_IRQ_MASK: dat_o <= {24'h000000, imask_reg};
        `SSS_ADR_CTRL:     dat_o <= {24'h000000, ctrl_reg};
        default:           dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // sss_supervisor
